// ==== hdl/hbridge_pwm_chopper_control.sv ====
// What this block does
// - Pulse high drives, pulse low short-brakes
// - Pulse accepted on dedicated pin or direction pins
// - Dead interval between upper and lower turn-on
// - Dead interval on direction and brake changes
// - Discharge phase drives short brake
// - Sense overvoltage turns outputs off, fault high
// - Overvoltage shutdown stays latched
// - Both direction inputs low clear latch
// - Enter discharge on sense comparator threshold
// - Discharge lasts four chopping clocks
// - Chopping clock comes from oscillator input
// - Still above threshold repeats discharge period
// - Charge holds until threshold reached again
// - Threshold crossing always runs full discharge
// - Short brake wins over drive requests
// - Fault high on any shutdown; latched ones released by inputs, lockout releases when it drops
//
// Purpose: Full-bridge control: pulse speed, dead time, chopping, sense latch-off
// Assumes: chopOscCap is the oscillator square wave, slow against clk
// Notes:   Fault output is open drain; bridge legs give gate commands per switch

`timescale 1ns/1ps

module hbridge_pwm_chopper_control
    import hbpc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      dirSelA,
    input  wire logic      dirSelB,
    input  wire logic      pwmIn,
    input  wire logic      chopOscCap,
    input  wire logic      senseTrip,
    input  wire logic      senseOverVolt,
    input  wire logic      overcurrentLatch,
    input  wire logic      otherLockout,
    output hbpc_leg_t      bridgeLegA,
    output hbpc_leg_t      bridgeLegB,
    output logic           bridgeLegAOe,
    output logic           bridgeLegBOe,
    output logic           faultOut,
    output logic           faultOutOe
);

    // Two-stage synchronisers for every pin input
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncIn;
    assign rawIn = {otherLockout, overcurrentLatch, senseOverVolt, senseTrip,
                    chopOscCap, pwmIn, dirSelB, dirSelA};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic sync1_reg, sync2_reg;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end else begin
                    sync1_reg <= rawIn[gi];
                    sync2_reg <= sync1_reg;
                end
            end
            assign syncIn[gi] = sync2_reg;
        end
    endgenerate

    logic inA, inB, pwmS, oscS, tripS, ovS, ocS, lockS;
    assign {lockS, ocS, ovS, tripS, oscS, pwmS, inB, inA} = syncIn;

    // Each rising oscillator edge is one chopping clock
    logic       oscPrev_reg, oscPrev_next;
    logic       chopTick;

    always_comb begin
        oscPrev_next = oscS;
        chopTick     = 1'b0;
        if (oscS && !oscPrev_reg) begin
            chopTick = 1'b1;
        end
    end

    // Chopping phase machine
    hbpc_chop_t chop_reg, chop_next;
    logic [2:0] tick_reg, tick_next;

    always_comb begin
        chop_next = chop_reg;
        tick_next = tick_reg;
        case (chop_reg)
            CH_CHARGE: begin
                if (tripS) begin
                    chop_next = CH_DISCHARGE;
                    tick_next = 3'h0;
                end
            end
            CH_DISCHARGE: begin
                if (chopTick) begin
                    if (tick_reg == DISCH_TICKS - 3'h1) begin
                        tick_next = 3'h0;
                        // Re-arm if still above threshold
                        if (!tripS) begin
                            chop_next = CH_CHARGE;
                        end
                    end else begin
                        tick_next = tick_reg + 3'h1;
                    end
                end
            end
            default: begin
                chop_next = CH_CHARGE;
                tick_next = 3'h0;
            end
        endcase
    end

    // Fault latch: sense overvoltage and overcurrent latch, lockout is live
    logic ovLatch_reg, ovLatch_next;
    logic releaseReq;
    assign releaseReq = !inA && !inB;

    always_comb begin
        ovLatch_next = ovLatch_reg;
        if (ovS || ocS) begin
            ovLatch_next = 1'b1;
        end else if (releaseReq) begin
            ovLatch_next = 1'b0;
        end
    end

    logic shutdown;
    assign shutdown = ovLatch_reg || ovS || ocS || lockS;

    // Bridge state selection
    hbpc_bridge_t bridgeReq;
    logic         pwmOnA, pwmOnB;

    always_comb begin
        // Pulse on direction pins: one pin high, other pulsing
        bridgeReq = BR_STOP;
        pwmOnA    = inA && !inB;
        pwmOnB    = inB && !inA;
        if (shutdown || releaseReq) begin
            bridgeReq = BR_STOP;
        end else if ((inA && inB) || !pwmS || chop_reg == CH_DISCHARGE) begin
            bridgeReq = BR_BRAKE;
        end else if (pwmOnA) begin
            bridgeReq = BR_REV;
        end else if (pwmOnB) begin
            bridgeReq = BR_FWD;
        end
    end

    hbpc_leg_t reqA, reqB;

    always_comb begin
        case (bridgeReq)
            BR_FWD: begin
                reqA = LEG_LOW;
                reqB = LEG_HIGH;
            end
            BR_REV: begin
                reqA = LEG_HIGH;
                reqB = LEG_LOW;
            end
            BR_BRAKE: begin
                reqA = LEG_LOW;
                reqB = LEG_LOW;
            end
            default: begin
                reqA = LEG_OFF;
                reqB = LEG_OFF;
            end
        endcase
    end

    hbpc_leg_t gateA, gateB;

    hbpc_dead_leg u_leg_a (
        .clk     (clk),
        .rst_n   (rst_n),
        .legReq  (reqA),
        .legGate (gateA)
    );

    hbpc_dead_leg u_leg_b (
        .clk     (clk),
        .rst_n   (rst_n),
        .legReq  (reqB),
        .legGate (gateB)
    );

    // Output registers
    hbpc_leg_t legA_reg, legB_reg;
    logic      oeA_reg, oeB_reg, fault_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oscPrev_reg <= 1'b0;
            chop_reg    <= CH_CHARGE;
            tick_reg    <= 3'h0;
            ovLatch_reg <= 1'b0;
            legA_reg    <= LEG_OFF;
            legB_reg    <= LEG_OFF;
            oeA_reg     <= 1'b0;
            oeB_reg     <= 1'b0;
            fault_reg   <= 1'b0;
        end else begin
            oscPrev_reg <= oscPrev_next;
            chop_reg    <= chop_next;
            tick_reg    <= tick_next;
            ovLatch_reg <= ovLatch_next;
            legA_reg    <= shutdown ? LEG_OFF : gateA;
            legB_reg    <= shutdown ? LEG_OFF : gateB;
            oeA_reg     <= !shutdown && (gateA != LEG_OFF);
            oeB_reg     <= !shutdown && (gateB != LEG_OFF);
            // Open drain: released (high) on fault
            fault_reg   <= !shutdown;
        end
    end

    assign bridgeLegA   = legA_reg;
    assign bridgeLegB   = legB_reg;
    assign bridgeLegAOe = oeA_reg;
    assign bridgeLegBOe = oeB_reg;
    assign faultOut     = 1'b0;
    assign faultOutOe   = fault_reg;

    a_ov_outputs_off: assert property (@(posedge clk) disable iff (!rst_n)
        ovLatch_reg |=> (!oeA_reg && !oeB_reg && !faultOutOe))
        else $error("Outputs active during latch");
    a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (ovLatch_reg && !releaseReq) |=> ovLatch_reg)
        else $error("Latch dropped without release");
    a_latch_release: assert property (@(posedge clk) disable iff (!rst_n)
        (ovLatch_reg && releaseReq && !ovS && !ocS) |=> !ovLatch_reg)
        else $error("Latch not released");
    a_trip_discharge: assert property (@(posedge clk) disable iff (!rst_n)
        (chop_reg == CH_CHARGE && tripS) |=> chop_reg == CH_DISCHARGE)
        else $error("Trip missed");
    a_discharge_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (chop_reg == CH_DISCHARGE && tick_reg != DISCH_TICKS - 3'h1) |=>
        chop_reg == CH_DISCHARGE) else $error("Discharge cut short");
    a_redischarge: assert property (@(posedge clk) disable iff (!rst_n)
        (chop_reg == CH_DISCHARGE && tripS) |=> chop_reg == CH_DISCHARGE)
        else $error("Charged while above threshold");
    a_charge_stays: assert property (@(posedge clk) disable iff (!rst_n)
        (chop_reg == CH_CHARGE && !tripS) |=> chop_reg == CH_CHARGE)
        else $error("Left charge without trip");
    a_brake_priority: assert property (@(posedge clk) disable iff (!rst_n)
        (chop_reg == CH_DISCHARGE && !shutdown && !releaseReq) |->
        bridgeReq == BR_BRAKE) else $error("Brake not selected");

    c_discharge: cover property (@(posedge clk) disable iff (!rst_n)
        chop_reg == CH_DISCHARGE ##1 chop_reg == CH_CHARGE);
    c_latch: cover property (@(posedge clk) disable iff (!rst_n)
        ovLatch_reg ##1 !ovLatch_reg);
    c_pwm_brake: cover property (@(posedge clk) disable iff (!rst_n)
        bridgeReq == BR_FWD ##[1:50] bridgeReq == BR_BRAKE);

endmodule : hbridge_pwm_chopper_control

// ==== hdl/hbpc_pkg.sv ====
// Purpose: Shared types and constants for the bridge chopper control block
// Assumes: 40 MHz system clock
// Notes:   Leg drive encodes upper and lower switch gate commands

package hbpc_pkg;

    // Gate commands of one bridge leg
    typedef struct packed {
        logic upper;
        logic lower;
    } hbpc_leg_t;

    // Requested bridge state
    typedef enum logic [2:0] {
        BR_STOP  = 3'b000,
        BR_FWD   = 3'b001,
        BR_REV   = 3'b010,
        BR_BRAKE = 3'b011
    } hbpc_bridge_t;

    // Chopper phase
    typedef enum logic [1:0] {
        CH_CHARGE    = 2'b00,
        CH_DISCHARGE = 2'b01
    } hbpc_chop_t;

    localparam int          CLK_HZ        = 40_000_000;
    localparam int          DEAD_NS       = 500;
    localparam int          DEAD_CYC      = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [4:0]  DEAD_CNT      = 5'(DEAD_CYC);
    localparam logic [2:0]  DISCH_TICKS   = 3'h4;
    localparam logic [1:0]  OSC_TICK_DIV  = 2'h3;
    localparam hbpc_leg_t   LEG_OFF       = '{upper: 1'b0, lower: 1'b0};
    localparam hbpc_leg_t   LEG_HIGH      = '{upper: 1'b1, lower: 1'b0};
    localparam hbpc_leg_t   LEG_LOW       = '{upper: 1'b0, lower: 1'b1};

endpackage : hbpc_pkg

// ==== hdl/hbpc_dead_leg.sv ====
// Purpose: One bridge leg with dead interval between upper and lower turn-on
// Assumes: Requests arrive synchronous to clk
// Notes:   Off request takes effect at once; only turn-on is delayed

`timescale 1ns/1ps

module hbpc_dead_leg
    import hbpc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  hbpc_leg_t      legReq,
    output hbpc_leg_t      legGate
);

    hbpc_leg_t  gate_reg, gate_next;
    logic [4:0] dead_reg, dead_next;

    always_comb begin
        gate_next = gate_reg;
        dead_next = dead_reg;
        if (legReq == LEG_OFF) begin
            gate_next = LEG_OFF;
            // Re-arm so a later turn-on of the other side still waits
            if (gate_reg != LEG_OFF) begin
                dead_next = DEAD_CNT;
            end
        end else if (legReq != gate_reg) begin
            // Switching sides: go off first, wait, then turn on
            if (gate_reg != LEG_OFF) begin
                gate_next = LEG_OFF;
                dead_next = DEAD_CNT;
            end else if (dead_reg != 5'h0_0) begin
                dead_next = dead_reg - 5'h0_1;
            end else begin
                gate_next = legReq;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg <= LEG_OFF;
            dead_reg <= DEAD_CNT;
        end else begin
            gate_reg <= gate_next;
            dead_reg <= dead_next;
        end
    end

    assign legGate = gate_reg;

    a_leg_no_shoot: assert property (@(posedge clk) disable iff (!rst_n)
        !(gate_reg.upper && gate_reg.lower)) else $error("Leg shoot-through");

    a_leg_dead_gap: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(gate_reg) == LEG_HIGH && gate_reg == LEG_OFF) |->
        !(gate_reg.lower) [*8]) else $error("Dead interval too short");

endmodule : hbpc_dead_leg

// ==== verif/hbpc_host_model.sv ====
// Purpose: Host side that drives the direction and pulse inputs
// Assumes: Bench changes cmd only at falling clock edges
// Notes:   Pulse rides on the dedicated pin or on the direction pins

`timescale 1ns/1ps

module hbpc_host_model
    import hbpc_pkg::*;
(
    input  hbpc_bridge_t cmd,
    input  wire logic    pwmLvl,
    input  wire logic    pwmOnDir,
    output logic         dirSelA,
    output logic         dirSelB,
    output logic         pwmIn
);
    logic [1:0] dirs;

    always_comb begin
        case (cmd)
            BR_FWD:   dirs = 2'h1;
            BR_REV:   dirs = 2'h2;
            BR_BRAKE: dirs = 2'h3;
            default:  dirs = 2'h0;
        endcase
        // Low phase on the direction pins raises the idle pin
        pwmIn = pwmOnDir | pwmLvl;
        {dirSelA, dirSelB} = (pwmOnDir && !pwmLvl && dirs != 2'h0) ? 2'h3 : dirs;
    end
endmodule : hbpc_host_model

// ==== verif/test_hbridge_pwm_chopper_control.sv ====
// Purpose: Self-checking bench for the bridge chopper control block
// Assumes: Oscillator square wave with an 8 clock period
// Notes:   Leg changes that swap a side wait out the dead interval

`timescale 1ns/1ps

module test_hbridge_pwm_chopper_control;
    import hbpc_pkg::*;

    logic         clk, rst_n, chopOscCap, senseTrip, pwmLvl, pwmOnDir;
    logic         dirSelA, dirSelB, pwmIn, faultOut, faultOutOe, bridgeLegAOe, bridgeLegBOe;
    logic [2:0]   fltSrc;
    hbpc_bridge_t cmd;
    hbpc_leg_t    bridgeLegA, bridgeLegB;
    hbpc_leg_t    lastOn [2];
    int           offRun [2];
    int           fail_count, n_compared;
    wire  [6:0]   obs = {bridgeLegA, bridgeLegB, bridgeLegAOe, bridgeLegBOe, faultOutOe};

    hbpc_host_model i_hbpc_host_model (.cmd(cmd), .pwmLvl(pwmLvl), .pwmOnDir(pwmOnDir),
        .dirSelA(dirSelA), .dirSelB(dirSelB), .pwmIn(pwmIn));

    hbridge_pwm_chopper_control i_hbridge_pwm_chopper_control (.clk(clk), .rst_n(rst_n),
        .dirSelA(dirSelA), .dirSelB(dirSelB), .pwmIn(pwmIn), .chopOscCap(chopOscCap),
        .senseTrip(senseTrip), .senseOverVolt(fltSrc[0]), .overcurrentLatch(fltSrc[1]),
        .otherLockout(fltSrc[2]), .bridgeLegA(bridgeLegA), .bridgeLegB(bridgeLegB),
        .bridgeLegAOe(bridgeLegAOe), .bridgeLegBOe(bridgeLegBOe), .faultOut(faultOut),
        .faultOutOe(faultOutOe));

    task err(string msg);
        fail_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : err

    function automatic logic [6:0] expect_out(hbpc_bridge_t s, logic flt);
        case (s)
            BR_FWD:   return {LEG_LOW, LEG_HIGH, 2'h3, ~flt};
            BR_REV:   return {LEG_HIGH, LEG_LOW, 2'h3, ~flt};
            BR_BRAKE: return {LEG_LOW, LEG_LOW, 2'h3, ~flt};
            default:  return {LEG_OFF, LEG_OFF, 2'h0, ~flt};
        endcase
    endfunction : expect_out

    // Waits up to n cycles for the outputs, then compares once
    task settle(hbpc_bridge_t s, logic flt, int n, string what);
        logic [6:0] want;
        want = expect_out(s, flt);
        for (int i = 0; i < n && obs !== want; i++) @(negedge clk);
        n_compared++;
        if (obs !== want) err($sformatf("%s got %h want %h", what, obs, want));
    endtask : settle

    task drive(hbpc_bridge_t c, logic lvl);
        @(negedge clk);
        cmd = c;
        pwmLvl = lvl;
    endtask : drive

    task automatic t_modes;
        hbpc_bridge_t seq [5] = '{BR_FWD, BR_REV, BR_BRAKE, BR_FWD, BR_STOP};
        foreach (seq[i]) begin
            drive(seq[i], 1'h1);
            settle(seq[i], 1'h0, 40, "mode");
        end
    endtask : t_modes

    task t_pwm;
        for (int k = 0; k < 2; k++) begin
            pwmOnDir = k[0];
            drive(BR_REV, 1'h1);
            settle(BR_REV, 1'h0, 40, "pulse high");
            drive(BR_REV, 1'h0);
            settle(BR_BRAKE, 1'h0, 40, "pulse low");
        end
        pwmOnDir = 1'h0;
    endtask : t_pwm

    task t_chop;
        drive(BR_FWD, 1'h1);
        settle(BR_FWD, 1'h0, 40, "charge");
        senseTrip = 1'h1;
        repeat (3) @(negedge clk);
        senseTrip = 1'h0;
        settle(BR_BRAKE, 1'h0, 30, "discharge");
        // Four ticks plus sync and dead interval: drive back 51 to 58 cycles after trip
        repeat (24) @(negedge clk);
        n_compared++;
        if (obs === expect_out(BR_FWD, 1'h0)) err("discharge span too short");
        settle(BR_FWD, 1'h0, 12, "recharge");
        repeat (40) @(negedge clk);
        settle(BR_FWD, 1'h0, 1, "charge holds");
        senseTrip = 1'h1;
        repeat (78) @(negedge clk);
        settle(BR_BRAKE, 1'h0, 1, "repeat discharge");
        senseTrip = 1'h0;
        settle(BR_FWD, 1'h0, 100, "charge again");
    endtask : t_chop

    task t_fault;
        for (int k = 0; k < 3; k++) begin
            drive(BR_FWD, 1'h1);
            settle(BR_FWD, 1'h0, 40, "before fault");
            fltSrc[k] = 1'h1;
            settle(BR_STOP, 1'h1, 6, "shutdown");
            repeat (3) @(negedge clk);
            fltSrc[k] = 1'h0;
            repeat (20) @(negedge clk);
            if (k < 2) begin
                settle(BR_STOP, 1'h1, 1, "latched");
                drive(BR_STOP, 1'h1);
                settle(BR_STOP, 1'h0, 6, "release");
                drive(BR_FWD, 1'h1);
            end
            settle(BR_FWD, 1'h0, 40, "resume");
        end
    endtask : t_fault

    task end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Shoot-through and dead interval watch on both legs
    always @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            hbpc_leg_t g;
            g = k ? bridgeLegB : bridgeLegA;
            if (g.upper === 1'h1 && g.lower === 1'h1) err("both switches on");
            if (g === LEG_OFF) offRun[k]++;
            else begin
                if (g !== lastOn[k] && lastOn[k] !== LEG_OFF && offRun[k] < int'(DEAD_CNT))
                    err("dead interval short");
                lastOn[k] = g;
                offRun[k] = 0;
            end
        end
        if (rst_n && faultOut !== 1'h0) err("fault data not low");
    end

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        chopOscCap = 1'h0;
        forever begin
            repeat (4) @(negedge clk);
            chopOscCap = ~chopOscCap;
        end
    end

    initial begin
        #(25 * 20000);
        err("timeout");
        end_of_test();
    end

    initial begin
        rst_n = 1'h0;
        cmd = BR_STOP;
        pwmLvl = 1'h1;
        pwmOnDir = 1'h0;
        senseTrip = 1'h0;
        fltSrc = 3'h0;
        lastOn = '{LEG_OFF, LEG_OFF};
        offRun = '{0, 0};
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        settle(BR_STOP, 1'h0, 10, "after reset");
        t_modes();
        t_pwm();
        t_chop();
        t_fault();
        end_of_test();
    end
endmodule : test_hbridge_pwm_chopper_control
